// ==== rtl/pnp_resource_config_decode.sv ====
/*
 * plug and play resource configuration registers with io, boot rom, shared
 * memory decode and interrupt / dma request steering.
 * assumes a classic wishbone master on ref_clk, isa address and strobes
 * already synchronous to ref_clk, and an eeprom loader giving a load pulse.
 */
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps

// How it works
// - interrupt select picks one of eight lines
// - no interrupt drive before activate is set
// - type bit: one level, zero edge
// - polarity bit reads inverse of type
// - io match against address bits 8..5
// - eeprom load fills io, dma, rom bases
// - dma select picks channel 3,5,6,7
// - bus master dma request gated by eeprom valid or sequential write done
// - rom window at C0000 plus base*8K
// - wide bit gives 16-bit, not bus master
// - size top bit clear means no rom
// - shared memory match on address 16..13
// - shared memory match output is active low
// - rom read only inside base and size
module pnp_resource_config_decode
    import pnp_cfg_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic [31:0]          wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic                 wb_we_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    output logic                      wb_ack_o,
    input  wire logic                 eepromLoad,
    input  wire eeprom_load_s         eepromData,
    input  wire logic                 eeprom_valid,
    input  wire logic [23:0]          sysAddr,
    input  wire logic                 memRead,
    input  wire logic                 irqReq,
    input  wire logic                 dmaReq,
    output logic [IRQ_LINES-1:0]      irqOut,
    output logic [IRQ_LINES-1:0]      irqOe,
    output logic [DMA_LINES-1:0]      dmaReqOut,
    output logic [DMA_LINES-1:0]      dmaReqOe,
    output logic                      ioHit,
    output logic                      bootromHit,
    output logic                      bootromWide,
    output logic                      shared_mem_match_n
);

    // ----------------------------------------------------------------
    // configuration state
    // ----------------------------------------------------------------
    logic [3:0] irqSelect_q;
    logic       irqType_q;
    logic [3:0] io_base_match_q;
    logic [2:0] dmaSelect_q;
    logic [3:0] bootrom_base_match_q;
    logic       bootrom_wide_access_q;
    logic [3:0] bootrom_size_q;
    logic [3:0] sharedMemBase_q;
    logic       activate_q;
    logic       busMaster_q;
    logic       seqDone_q;
    bus_state_e busState_q;
    logic [7:0] regIdx;
    logic       wrStrobe;
    logic [7:0] wrByte;
    logic [7:0] rdByte;
    logic       irqPolarity;

    function automatic logic [3:0] romBlocks(input logic [3:0] size);
        // number of 8K blocks minus one; zero when no rom
        case (size)
            4'hF:    romBlocks = 4'h0;
            4'hE:    romBlocks = 4'h1;
            4'hC:    romBlocks = 4'h3;
            4'h8:    romBlocks = 4'h7;
            default: romBlocks = 4'h0;
        endcase
    endfunction : romBlocks

    function automatic logic romSized(input logic [3:0] size);
        romSized = size[3] && (size == 4'hF || size == 4'hE || size == 4'hC || size == 4'h8);
    endfunction : romSized

    assign regIdx   = wb_adr_i[9:2];
    assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && busState_q == BUS_IDLE;
    assign wrByte   = wb_dat_i[7:0];
    assign irqPolarity = ~irqType_q;

    // ----------------------------------------------------------------
    // wishbone handshake
    // ----------------------------------------------------------------
    // ack comes one cycle after the request and drops the cycle after
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busState_q <= BUS_IDLE;
            wb_ack_o   <= 1'b0;
        end else begin
            case (busState_q)
                BUS_IDLE: begin
                    wb_ack_o <= wb_cyc_i && wb_stb_i;
                    if (wb_cyc_i && wb_stb_i) begin
                        busState_q <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    wb_ack_o   <= 1'b0;
                    busState_q <= BUS_WAIT;
                end
                BUS_WAIT: begin
                    wb_ack_o <= 1'b0;
                    if (!(wb_cyc_i && wb_stb_i)) begin
                        busState_q <= BUS_IDLE;
                    end
                end
                default: begin
                    wb_ack_o   <= 1'b0;
                    busState_q <= BUS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irqSelect_q           <= IRQ_SEL_RST;
            irqType_q             <= 1'b0;
            io_base_match_q       <= BASE_RST;
            dmaSelect_q           <= DMA_SEL_RST;
            bootrom_base_match_q  <= BASE_RST;
            bootrom_wide_access_q <= 1'b0;
            bootrom_size_q        <= SIZE_RST;
            sharedMemBase_q       <= BASE_RST;
            activate_q            <= 1'b0;
            busMaster_q           <= 1'b0;
        end else if (eepromLoad) begin
            io_base_match_q      <= eepromData.ioBaseMatch;
            bootrom_base_match_q <= eepromData.bootromBaseMatch;
            dmaSelect_q          <= eepromData.dmaSelect;
        end else if (wrStrobe) begin
            if (regIdx == IDX_IRQ_SELECT_CFG) begin
                irqSelect_q <= wrByte[3:0];
            end else if (regIdx == IDX_IRQ_TYPE_CFG) begin
                irqType_q <= wrByte[0];
            end else if (regIdx == IDX_IO_BASE_HI) begin
                io_base_match_q[3] <= wrByte[HI_FIELD_BIT];
            end else if (regIdx == IDX_IO_BASE_LO) begin
                io_base_match_q[2:0] <= wrByte[LO_FIELD_MSB:LO_FIELD_LSB];
            end else if (regIdx == IDX_DMA_SELECT_CFG) begin
                dmaSelect_q <= wrByte[2:0];
            end else if (regIdx == IDX_BOOTROM_BASE_HI) begin
                bootrom_base_match_q[3] <= wrByte[HI_FIELD_BIT];
            end else if (regIdx == IDX_BOOTROM_BASE_LO) begin
                bootrom_base_match_q[2:0] <= wrByte[LO_FIELD_MSB:LO_FIELD_LSB];
            end else if (regIdx == IDX_BOOTROM_WIDTH_CFG) begin
                bootrom_wide_access_q <= wrByte[WIDE_BIT];
            end else if (regIdx == IDX_BOOTROM_SIZE_HI) begin
                bootrom_size_q[3] <= wrByte[HI_FIELD_BIT];
            end else if (regIdx == IDX_BOOTROM_SIZE_LO) begin
                bootrom_size_q[2:0] <= wrByte[LO_FIELD_MSB:LO_FIELD_LSB];
            end else if (regIdx == IDX_SHARED_MEM_BASE_HI) begin
                sharedMemBase_q[3] <= wrByte[HI_FIELD_BIT];
            end else if (regIdx == IDX_SHARED_MEM_BASE_LO) begin
                sharedMemBase_q[2:0] <= wrByte[LO_FIELD_MSB:LO_FIELD_LSB];
            end else if (regIdx == IDX_CTRL) begin
                activate_q  <= wrByte[ACTIVATE_BIT];
                busMaster_q <= wrByte[BUSMASTER_BIT];
            end
        end
    end

    // sequential write done: set by the last config write in a write burst,
    // here taken as any write of the dma select register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seqDone_q <= 1'b0;
        end else if (wrStrobe && regIdx == IDX_DMA_SELECT_CFG) begin
            seqDone_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb begin
        rdByte = 8'h00;
        if (regIdx == IDX_IRQ_SELECT_CFG) begin
            rdByte = {4'h0, irqSelect_q};
        end else if (regIdx == IDX_IRQ_TYPE_CFG) begin
            rdByte = {6'h00, irqPolarity, irqType_q};
        end else if (regIdx == IDX_IO_BASE_HI) begin
            rdByte = IO_HI_FIXED | {7'h00, io_base_match_q[3]};
        end else if (regIdx == IDX_IO_BASE_LO) begin
            rdByte = {io_base_match_q[2:0], 5'h00};
        end else if (regIdx == IDX_DMA_SELECT_CFG) begin
            rdByte = {5'h00, dmaSelect_q};
        end else if (regIdx == IDX_BOOTROM_BASE_HI) begin
            rdByte = BASE_HI_FIXED | {7'h00, bootrom_base_match_q[3]};
        end else if (regIdx == IDX_BOOTROM_BASE_LO) begin
            rdByte = {bootrom_base_match_q[2:0], 5'h00};
        end else if (regIdx == IDX_BOOTROM_WIDTH_CFG) begin
            rdByte = {6'h00, bootrom_wide_access_q, 1'b0};
        end else if (regIdx == IDX_BOOTROM_SIZE_HI) begin
            rdByte = SIZE_HI_FIXED | {7'h00, bootrom_size_q[3]};
        end else if (regIdx == IDX_BOOTROM_SIZE_LO) begin
            rdByte = {bootrom_size_q[2:0], 5'h00};
        end else if (regIdx == IDX_SHARED_MEM_BASE_HI) begin
            rdByte = BASE_HI_FIXED | {7'h00, sharedMemBase_q[3]};
        end else if (regIdx == IDX_SHARED_MEM_BASE_LO) begin
            rdByte = {sharedMemBase_q[2:0], 5'h00};
        end else if (regIdx == IDX_CTRL) begin
            rdByte = {6'h00, busMaster_q, activate_q};
        end else if (regIdx == IDX_STATUS) begin
            rdByte = {5'h00, seqDone_q, eeprom_valid, activate_q};
        end
    end

    // unmapped indices read zero and are acked; writes to them are dropped
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (busState_q == BUS_IDLE && wb_cyc_i && wb_stb_i) begin
            wb_dat_o <= {24'h000000, rdByte};
        end
    end

    // ----------------------------------------------------------------
    // interrupt and dma steering
    // ----------------------------------------------------------------
    // lines: 0=3 1=4 2=5 3=9 4=10 5=11 6=12 7=15
    function automatic logic [IRQ_LINES-1:0] irqDecode(input logic [3:0] sel);
        case (sel)
            4'h4:    irqDecode = 8'h02;
            4'h5:    irqDecode = 8'h04;
            4'h9:    irqDecode = 8'h08;
            4'hA:    irqDecode = 8'h10;
            4'hB:    irqDecode = 8'h20;
            4'hC:    irqDecode = 8'h40;
            4'hF:    irqDecode = 8'h80;
            default: irqDecode = 8'h01;
        endcase
    endfunction : irqDecode

    // lines: 0=3 1=5 2=6 3=7
    function automatic logic [DMA_LINES-1:0] dmaDecode(input logic [2:0] sel);
        case (sel)
            3'h5:    dmaDecode = 4'h2;
            3'h6:    dmaDecode = 4'h4;
            3'h7:    dmaDecode = 4'h8;
            default: dmaDecode = 4'h1;
        endcase
    endfunction : dmaDecode

    // level mode drives active low, edge mode active high
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irqOut <= '0;
            irqOe  <= '0;
        end else begin
            irqOe  <= activate_q ? irqDecode(irqSelect_q) : '0;
            irqOut <= irqDecode(irqSelect_q) & {IRQ_LINES{irqReq ^ irqType_q}};
        end
    end

    // shared memory mode has no dma request gating beyond the pair select
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dmaReqOut <= '0;
            dmaReqOe  <= '0;
        end else begin
            dmaReqOe  <= (!busMaster_q || eeprom_valid || seqDone_q) ?
                         dmaDecode(dmaSelect_q) : '0;
            dmaReqOut <= dmaDecode(dmaSelect_q) & {DMA_LINES{dmaReq}};
        end
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic [3:0] romBlk;
    logic       romHitComb;
    assign romBlk = sysAddr[16:13] - bootrom_base_match_q;
    assign romHitComb = sysAddr[23:17] == ROM_BASE[23:17] && romSized(bootrom_size_q)
                        && sysAddr[16:13] >= bootrom_base_match_q
                        && romBlk <= romBlocks(bootrom_size_q);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ioHit              <= 1'b0;
            bootromHit         <= 1'b0;
            bootromWide        <= 1'b0;
            shared_mem_match_n <= 1'b1;
        end else begin
            ioHit <= sysAddr[9] == IO_WINDOW_TOP[9] && sysAddr[8:5] == io_base_match_q;
            bootromHit <= memRead && romHitComb;
            bootromWide <= bootrom_wide_access_q && !busMaster_q;
            shared_mem_match_n <= !(sysAddr[16:13] == sharedMemBase_q);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_irq_gate;
        @(posedge ref_clk) disable iff (rst) !activate_q |=> irqOe == '0;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq driven before activate");

    property p_irq_sel;
        @(posedge ref_clk) disable iff (rst)
            activate_q && irqSelect_q == 4'hF |=> irqOe == 8'h80;
    endproperty
    a_irq_sel: assert property (p_irq_sel) else $error("irq15 not selected");

    // checked on the bus read path so a broken read mux is caught too
    sequence s_type_read;
        busState_q == BUS_IDLE && wb_cyc_i && wb_stb_i && regIdx == IDX_IRQ_TYPE_CFG;
    endsequence

    sequence s_type_inverse;
        wb_dat_o[1] != wb_dat_o[0];
    endsequence

    property p_pol;
        @(posedge ref_clk) disable iff (rst) s_type_read |=> s_type_inverse;
    endproperty
    a_pol: assert property (p_pol) else $error("polarity not inverse of type");

    property p_dma_gate;
        @(posedge ref_clk) disable iff (rst)
            busMaster_q && !eeprom_valid && !seqDone_q |=> dmaReqOe == '0;
    endproperty
    a_dma_gate: assert property (p_dma_gate) else $error("dma driven early");

    property p_dma_sel;
        @(posedge ref_clk) disable iff (rst)
            !busMaster_q && dmaSelect_q == 3'h6 |=> dmaReqOe == 4'h4;
    endproperty
    a_dma_sel: assert property (p_dma_sel) else $error("channel 6 not selected");

    property p_io;
        @(posedge ref_clk) disable iff (rst)
            sysAddr[9:5] == {1'b1, io_base_match_q} |=> ioHit;
    endproperty
    a_io: assert property (p_io) else $error("io base miss");

    property p_rom_none;
        @(posedge ref_clk) disable iff (rst) !bootrom_size_q[3] |=> !bootromHit;
    endproperty
    a_rom_none: assert property (p_rom_none) else $error("rom hit with no rom");

    property p_wide;
        @(posedge ref_clk) disable iff (rst) busMaster_q |=> !bootromWide;
    endproperty
    a_wide: assert property (p_wide) else $error("wide rom in bus master");

    property p_smem;
        @(posedge ref_clk) disable iff (rst)
            sysAddr[16:13] == sharedMemBase_q |=> !shared_mem_match_n;
    endproperty
    a_smem: assert property (p_smem) else $error("shared memory miss");

endmodule : pnp_resource_config_decode

// ==== rtl/pnp_cfg_pkg.sv ====
/*
 * constants and carrier types for the plug and play resource configuration bank.
 * assumes a classic wishbone slave with 32-bit data, one register per aligned word.
 */
package pnp_cfg_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_BOOTROM_BASE_HI    = 8'h40;
    localparam logic [7:0] IDX_BOOTROM_BASE_LO    = 8'h41;
    localparam logic [7:0] IDX_BOOTROM_WIDTH_CFG  = 8'h42;
    localparam logic [7:0] IDX_BOOTROM_SIZE_HI    = 8'h43;
    localparam logic [7:0] IDX_BOOTROM_SIZE_LO    = 8'h44;
    localparam logic [7:0] IDX_SHARED_MEM_BASE_HI = 8'h48;
    localparam logic [7:0] IDX_SHARED_MEM_BASE_LO = 8'h49;
    localparam logic [7:0] IDX_IO_BASE_HI         = 8'h60;
    localparam logic [7:0] IDX_IO_BASE_LO         = 8'h61;
    localparam logic [7:0] IDX_IRQ_SELECT_CFG     = 8'h70;
    localparam logic [7:0] IDX_IRQ_TYPE_CFG       = 8'h71;
    localparam logic [7:0] IDX_DMA_SELECT_CFG     = 8'h74;
    localparam logic [7:0] IDX_CTRL               = 8'h30;
    localparam logic [7:0] IDX_STATUS             = 8'h32;

    // ----------------------------------------------------------------
    // fixed bits of split registers
    // ----------------------------------------------------------------
    localparam logic [7:0] IO_HI_FIXED    = 8'h02;
    localparam logic [7:0] BASE_HI_FIXED  = 8'h0C;
    localparam logic [7:0] SIZE_HI_FIXED  = 8'hFE;
    localparam int         HI_FIELD_BIT   = 0;
    localparam int         LO_FIELD_MSB   = 7;
    localparam int         LO_FIELD_LSB   = 5;
    localparam int         WIDE_BIT       = 1;
    localparam int         ACTIVATE_BIT   = 0;
    localparam int         BUSMASTER_BIT  = 1;
    localparam int         SEQDONE_BIT    = 2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] IRQ_SEL_RST  = 4'h0;
    localparam logic [2:0] DMA_SEL_RST  = 3'h3;
    localparam logic [3:0] BASE_RST     = 4'h0;
    localparam logic [3:0] SIZE_RST     = 4'h0;

    // ----------------------------------------------------------------
    // address decode constants
    // ----------------------------------------------------------------
    localparam logic [9:0]  IO_WINDOW_TOP = 10'h200;
    localparam logic [23:0] ROM_BASE      = 24'h0C0000;
    localparam int          IRQ_LINES     = 8;
    localparam int          DMA_LINES     = 4;

    typedef struct packed {
        logic [3:0] ioBaseMatch;
        logic [3:0] bootromBaseMatch;
        logic [2:0] dmaSelect;
    } eeprom_load_s;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK  = 3'b010,
        BUS_WAIT = 3'b100
    } bus_state_e;

endpackage : pnp_cfg_pkg

// ==== dv/isa_host_model.sv ====
/*
 * isa host side model: registers the address and memory read strobe.
 * assumes the bench updates its requests just after a rising edge.
 */
`timescale 1ns/1ps

module isa_host_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [23:0] hostAddr,
    input  wire logic        hostRead,
    output logic      [23:0] sysAddr,
    output logic             memRead
);
    // ------------------------------------------------------------
    // address cycle
    // ------------------------------------------------------------
    // strobe only on reads
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sysAddr <= 24'h000000;
            memRead <= 1'b0;
        end else begin
            sysAddr <= hostAddr;
            memRead <= hostRead;
        end
    end
endmodule : isa_host_model

// ==== dv/tb.sv ====
/*
 * self-checking bench for the resource configuration bank.
 * assumes one-cycle wishbone answers and registered decode outputs.
 */
`timescale 1ns/1ps

module tb;
    import pnp_cfg_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic               ref_clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic        [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
    logic        [3:0]  wb_sel_i;
    logic               eepromLoad, eeprom_valid, memRead, irqReq, dmaReq;
    eeprom_load_s       eepromData;
    logic        [23:0] sysAddr, hostAddr;
    logic               hostRead, ioHit, bootromHit, bootromWide, shared_mem_match_n;
    logic        [7:0]  irqOut, irqOe;
    logic        [3:0]  dmaReqOut, dmaReqOe;
    int                 mismatches, checked;
    logic        [7:0]  rIdx [14] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h48, 8'h49,
                                     8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h30, 8'h50};
    logic        [7:0]  rVal [14] = '{8'h0C, 8'h00, 8'h00, 8'hFE, 8'h00, 8'h0C, 8'h00,
                                     8'h02, 8'h00, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00};
    logic        [3:0]  irqCode [8] = '{4'h0, 4'h4, 4'h5, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF};
    logic        [2:0]  dmaCode [4] = '{3'h3, 3'h5, 3'h6, 3'h7};

    pnp_resource_config_decode u_pnp_resource_config_decode (
        .ref_clk, .rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i,
        .wb_cyc_i, .wb_stb_i, .wb_ack_o, .eepromLoad, .eepromData, .eeprom_valid,
        .sysAddr, .memRead, .irqReq, .dmaReq, .irqOut, .irqOe, .dmaReqOut,
        .dmaReqOe, .ioHit, .bootromHit, .bootromWide, .shared_mem_match_n);
    isa_host_model u_isa_host_model (
        .ref_clk, .rst, .hostAddr, .hostRead, .sysAddr, .memRead);

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic final_report;
        if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // classic cycle: hold until ack is sampled, then release
    task automatic wbc(input logic [7:0] idx, input logic we, input logic [7:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_adr_i <= {22'h0, idx, 2'b00};
        wb_we_i  <= we;
        wb_dat_i <= {24'h0, wd};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            mismatches++;
            final_report();
        end
    endtask : wbc

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        wbc(idx, 1'b1, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] r;
        wbc(idx, 1'b0, 8'h00, r);
        chk("wb_dat_o", {24'h0, e}, r);
    endtask : rd

    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic host(input logic [23:0] a, input logic r);
        @(posedge ref_clk);
        hostAddr <= a;
        hostRead <= r;
        settle();
    endtask : host

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {wb_we_i, wb_cyc_i, wb_stb_i, eepromLoad, eeprom_valid, hostRead} = '0;
        {wb_adr_i, wb_dat_i, hostAddr, eepromData} = '0;
        wb_sel_i = 4'hF;
        irqReq = 1'b1;
        dmaReq = 1'b1;
        rst = 1'b1;
        mismatches = 0;
        checked = 0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        wr(8'h50, 8'hFF);
        // reset values, polarity inverse of type
        for (int i = 0; i < 14; i++) rd(rIdx[i], rVal[i]);
        settle();
        chk("irqOe", 0, irqOe);
        @(posedge ref_clk);
        eepromData <= '{4'h5, 4'h2, 3'h6};
        eepromLoad <= 1'b1;
        @(posedge ref_clk);
        eepromLoad <= 1'b0;
        rd(8'h61, 8'hA0);
        rd(8'h41, 8'h40);
        rd(8'h74, 8'h06);
        host(24'h0002A0, 1'b0);
        chk("ioHit", 1, ioHit);
        wr(8'h60, 8'h01);
        wr(8'h61, 8'h40);
        host(24'h000340, 1'b0);
        chk("ioHit", 1, ioHit);
        host(24'h000320, 1'b0);
        chk("ioHit", 0, ioHit);
        wr(8'h30, 8'h03);
        settle();
        chk("dmaReqOe", 0, dmaReqOe);
        @(posedge ref_clk);
        eeprom_valid <= 1'b1;
        settle();
        chk("dmaReqOe", 4, dmaReqOe);
        for (int i = 0; i < 8; i++) begin
            wr(8'h70, {4'h0, irqCode[i]});
            settle();
            chk("irqOe", 32'h1 << i, irqOe);
            chk("irqOut", 1, irqOut[i]);
        end
        wr(8'h71, 8'h03);
        rd(8'h71, 8'h01);
        settle();
        chk("irqOut", 0, irqOut[7]);
        @(posedge ref_clk);
        irqReq <= 1'b0;
        settle();
        chk("irqOut", 1, irqOut[7]);
        @(posedge ref_clk);
        irqReq <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(8'h74, {5'h0, dmaCode[i]});
            settle();
            chk("dmaReqOe", 32'h1 << i, dmaReqOe);
            chk("dmaReqOut", 1, dmaReqOut[i]);
        end
        @(posedge ref_clk);
        eeprom_valid <= 1'b0;
        dmaReq       <= 1'b0;
        settle();
        chk("dmaReqOe", 8, dmaReqOe);
        chk("dmaReqOut", 0, dmaReqOut[3]);
        rd(8'h32, 8'h05);
        wr(8'h42, 8'h02);
        settle();
        chk("bootromWide", 0, bootromWide);
        wr(8'h30, 8'h01);
        settle();
        chk("bootromWide", 1, bootromWide);
        wr(8'h40, 8'h00);
        wr(8'h41, 8'h80);
        wr(8'h43, 8'h01);
        wr(8'h44, 8'h80);
        host(24'h0C8000, 1'b1);
        chk("bootromHit", 1, bootromHit);
        host(24'h0CFFFF, 1'b1);
        chk("bootromHit", 1, bootromHit);
        host(24'h0D0000, 1'b1);
        chk("bootromHit", 0, bootromHit);
        host(24'h0C6000, 1'b1);
        chk("bootromHit", 0, bootromHit);
        host(24'h0C8000, 1'b0);
        chk("bootromHit", 0, bootromHit);
        wr(8'h43, 8'h00);
        host(24'h0C8000, 1'b1);
        chk("bootromHit", 0, bootromHit);
        wr(8'h40, 8'h01);
        wr(8'h41, 8'h00);
        wr(8'h43, 8'h01);
        wr(8'h44, 8'h00);
        host(24'h0DFFFF, 1'b1);
        chk("bootromHit", 1, bootromHit);
        host(24'h0E0000, 1'b1);
        chk("bootromHit", 0, bootromHit);
        // top bit set to agree with address bit 16
        wr(8'h48, 8'h01);
        wr(8'h49, 8'h60);
        host(24'h016000, 1'b0);
        chk("shared_mem_match_n", 0, shared_mem_match_n);
        host(24'h036000, 1'b0);
        chk("shared_mem_match_n", 0, shared_mem_match_n);
        host(24'h014000, 1'b0);
        chk("shared_mem_match_n", 1, shared_mem_match_n);
        final_report();
    end
endmodule : tb
